//--- fpx_pkg.sv
// constants and types shared by the deferred floating-point trap logic
package fpx_pkg;

    // number of exception flags in the status word and the mask field
    localparam int          FPX_NEXC     = 6;

    // flag and mask bit positions
    localparam int          FPX_EXC_INV  = 0;
    localparam int          FPX_EXC_DEN  = 1;
    localparam int          FPX_EXC_ZDIV = 2;
    localparam int          FPX_EXC_OVF  = 3;
    localparam int          FPX_EXC_UNF  = 4;
    localparam int          FPX_EXC_PREC = 5;

    // exceptions caught before the operation starts
    localparam logic [5:0]  FPX_PRE_OP_SEL = 6'h07;

    // values after reset and after initialise
    localparam logic [5:0]  FPX_RST_STATUS = 6'h00;
    localparam logic [5:0]  FPX_RST_MASK   = 6'h3f;
    localparam logic [5:0]  FPX_MASK_ALL   = 6'h3f;
    localparam logic [11:0] FPX_RST_STORE  = 12'h000;

    // kind of floating-point instruction presented at issue
    typedef enum logic [3:0] {
        fpx_kind_none,
        fpx_kind_arith,
        fpx_kind_wait,
        fpx_kind_init,
        fpx_kind_stenv,
        fpx_kind_save,
        fpx_kind_stsw,
        fpx_kind_stcw,
        fpx_kind_clex
    } fpx_kind_e;

endpackage : fpx_pkg

//--- fpx_eval_if.sv
// carrier between the sequencer and the exception evaluator
`timescale 1ns/100ps
interface fpx_eval_if;
    logic [5:0] flags;        // conditions raised by the current operation
    logic [5:0] mask;         // mask bits in force
    logic [5:0] unmasked;     // raised and not masked
    logic       any_unmasked; // at least one unmasked condition
    logic       write_ok;     // destination may be written

    modport req  (output flags, output mask, input unmasked, input any_unmasked, input write_ok);
    modport eval (input flags, input mask, output unmasked, output any_unmasked, output write_ok);
endinterface : fpx_eval_if

//--- fpx_exc_eval.sv
// combinational classification of the exceptions raised by one operation
`timescale 1ns/100ps
module fpx_exc_eval (
    fpx_eval_if.eval e
);

    ////////////////////////////////////////////////////////////////////////////
    // unmasked conditions and destination write permission
    assign e.unmasked     = e.flags & ~e.mask;
    assign e.any_unmasked = |e.unmasked;
    // an unmasked pre-operation fault leaves stack and memory untouched
    assign e.write_ok     = ~|(e.unmasked & fpx_pkg::FPX_PRE_OP_SEL);

endmodule : fpx_exc_eval

//--- fpx_exception_sync.sv
// deferred trap sequencing for unmasked floating-point exceptions
`timescale 1ns/100ps

module fpx_exception_sync (
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire logic                issue_valid,
    input  fpx_pkg::fpx_kind_e       issue_kind,
    input  wire logic [5:0]          exc_flags,
    input  wire logic                ctrl_wr,
    input  wire logic [5:0]          ctrl_wdata,
    output logic                     trap_req,
    output logic                     pending_summary_flag,
    output logic [5:0]               status_flags,
    output logic [5:0]               exc_masks,
    output logic                     result_wr,
    output logic                     fault_halt,
    output logic                     insn_done,
    output logic                     store_valid,
    output logic [11:0]              store_data
);

    ////////////////////////////////////////////////////////////////////////////
    // state and next values
    logic [5:0]  status_ff;
    logic [5:0]  mask_ff;
    logic        pend_ff;
    logic        trap_ff;
    logic        wr_ff;
    logic        halt_ff;
    logic        done_ff;
    logic        sv_ff;
    logic [11:0] sd_ff;
    logic [5:0]  nxt_status;
    logic [5:0]  nxt_mask;
    logic        nxt_pend;
    logic        nxt_trap;
    logic        nxt_wr;
    logic        nxt_halt;
    logic        nxt_done;
    logic        nxt_sv;
    logic [11:0] nxt_sd;
    logic        is_check;
    logic        is_nowait;

    fpx_eval_if ev ();

    ////////////////////////////////////////////////////////////////////////////
    // exception evaluator for the operation at issue
    assign ev.flags = exc_flags;
    assign ev.mask  = mask_ff;

    fpx_exc_eval u_eval (
        .e (ev.eval)
    );

    // instruction classes
    assign is_check  = issue_valid && (issue_kind == fpx_pkg::fpx_kind_arith ||
                                       issue_kind == fpx_pkg::fpx_kind_wait);
    assign is_nowait = issue_valid && (issue_kind == fpx_pkg::fpx_kind_init  ||
                                       issue_kind == fpx_pkg::fpx_kind_stenv ||
                                       issue_kind == fpx_pkg::fpx_kind_save  ||
                                       issue_kind == fpx_pkg::fpx_kind_stsw  ||
                                       issue_kind == fpx_pkg::fpx_kind_stcw  ||
                                       issue_kind == fpx_pkg::fpx_kind_clex);

    ////////////////////////////////////////////////////////////////////////////
    // next state per issued instruction; integer work is never held here
    always_comb
    begin
        nxt_status = status_ff;
        nxt_mask   = mask_ff;
        nxt_trap   = 1'b0;
        nxt_wr     = 1'b0;
        nxt_halt   = 1'b0;
        nxt_done   = 1'b0;
        nxt_sv     = 1'b0;
        nxt_sd     = sd_ff;
        if (ctrl_wr)
        begin
            nxt_mask = ctrl_wdata;
        end
        if (issue_valid)
        begin
            case (issue_kind)
                fpx_pkg::fpx_kind_arith,
                fpx_pkg::fpx_kind_wait:
                begin
                    if (pend_ff)
                    begin
                        nxt_trap = 1'b1;
                    end
                    else
                    begin
                        nxt_done = 1'b1;
                        if (issue_kind == fpx_pkg::fpx_kind_arith)
                        begin
                            nxt_status = status_ff | exc_flags;
                            nxt_halt   = ev.any_unmasked;
                            nxt_wr     = ev.write_ok;
                        end
                    end
                end
                fpx_pkg::fpx_kind_init:
                begin
                    nxt_status = fpx_pkg::FPX_RST_STATUS;
                    nxt_mask   = fpx_pkg::FPX_MASK_ALL;
                    nxt_done   = 1'b1;
                end
                fpx_pkg::fpx_kind_stenv,
                fpx_pkg::fpx_kind_save:
                begin
                    nxt_mask = fpx_pkg::FPX_MASK_ALL;
                    nxt_sv   = 1'b1;
                    nxt_sd   = {mask_ff, status_ff};
                    nxt_done = 1'b1;
                end
                fpx_pkg::fpx_kind_stsw,
                fpx_pkg::fpx_kind_stcw:
                begin
                    nxt_sv   = 1'b1;
                    nxt_sd   = {mask_ff, status_ff};
                    nxt_done = 1'b1;
                end
                fpx_pkg::fpx_kind_clex:
                begin
                    nxt_status = fpx_pkg::FPX_RST_STATUS;
                    nxt_done   = 1'b1;
                end
                default:
                begin
                    nxt_done = 1'b0;
                end
            endcase
        end
        // summary follows flags and masks, so masked flags never pend
        nxt_pend = |(nxt_status & ~nxt_mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // status word, masks and summary flag
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            status_ff <= fpx_pkg::FPX_RST_STATUS;
            mask_ff   <= fpx_pkg::FPX_RST_MASK;
            pend_ff   <= 1'b0;
        end
        else
        begin
            status_ff <= nxt_status;
            mask_ff   <= nxt_mask;
            pend_ff   <= nxt_pend;
        end
    end

    // trap delivery and execution results
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            trap_ff <= 1'b0;
            wr_ff   <= 1'b0;
            halt_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            trap_ff <= nxt_trap;
            wr_ff   <= nxt_wr;
            halt_ff <= nxt_halt;
            done_ff <= nxt_done;
        end
    end

    // store path of the non-waiting stenv, save, stsw and stcw instructions
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sv_ff <= 1'b0;
            sd_ff <= fpx_pkg::FPX_RST_STORE;
        end
        else
        begin
            sv_ff <= nxt_sv;
            sd_ff <= nxt_sd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops
    assign trap_req             = trap_ff;
    assign pending_summary_flag = pend_ff;
    assign status_flags         = status_ff;
    assign exc_masks            = mask_ff;
    assign result_wr            = wr_ff;
    assign fault_halt           = halt_ff;
    assign insn_done            = done_ff;
    assign store_valid          = sv_ff;
    assign store_data           = sd_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_store_pend;
        issue_valid && !ctrl_wr && pend_ff &&
        (issue_kind == fpx_pkg::fpx_kind_stsw || issue_kind == fpx_pkg::fpx_kind_stcw);
    endsequence

    sequence s_wait_next;
        issue_valid && !ctrl_wr && issue_kind == fpx_pkg::fpx_kind_wait;
    endsequence

    trap_on_pend_a: assert property (is_check && pend_ff |=> trap_ff && !done_ff && !wr_ff)
        else $error("pending exception did not trap");
    check_no_trap_a: assert property (is_check && !pend_ff |=> !trap_ff && done_ff)
        else $error("trap taken with nothing pending");
    idle_no_trap_a: assert property (pend_ff && !is_check |=> !trap_ff)
        else $error("trap raised without a checking instruction");
    defer_trap_a: assert property (issue_valid && issue_kind == fpx_pkg::fpx_kind_arith && !pend_ff &&
                                   ev.any_unmasked && !ctrl_wr |=> pend_ff && halt_ff && !trap_ff)
        else $error("unmasked exception not deferred");
    nowait_no_trap_a: assert property (is_nowait |=> !trap_ff && done_ff)
        else $error("non-waiting instruction trapped");
    discard_pend_a: assert property (is_nowait && !ctrl_wr && issue_kind != fpx_pkg::fpx_kind_stsw &&
                                     issue_kind != fpx_pkg::fpx_kind_stcw |=> !pend_ff)
        else $error("pending exception survived discard");
    store_keep_a: assert property (s_store_pend |=> $stable(status_ff) && $stable(mask_ff) && pend_ff)
        else $error("store changed status or masks");
    survive_trap_a: assert property (s_store_pend ##1 s_wait_next |=> trap_ff)
        else $error("pending lost across non-waiting store");
    masked_write_a: assert property (issue_valid && issue_kind == fpx_pkg::fpx_kind_arith && !pend_ff &&
                                     exc_flags != 6'h00 && !ev.any_unmasked && !ctrl_wr
                                     |=> wr_ff && !pend_ff && !halt_ff)
        else $error("masked exception pended or lost result");
    preop_nowrite_a: assert property (issue_valid && issue_kind == fpx_pkg::fpx_kind_arith && !pend_ff &&
                                      (ev.unmasked & fpx_pkg::FPX_PRE_OP_SEL) != 6'h00 |=> !wr_ff)
        else $error("pre-operation fault wrote destination");
    summary_flag_a: assert property (pend_ff == |(status_ff & ~mask_ff))
        else $error("summary flag disagrees with flags and masks");
    write_source_a: assert property (wr_ff |-> done_ff && $past(issue_kind) == fpx_pkg::fpx_kind_arith)
        else $error("register result written outside arithmetic");

endmodule : fpx_exception_sync

//--- fpx_issue_model.sv
// issue stream model that presents floating-point instructions to the trap logic
`timescale 1ns/100ps
module fpx_issue_model (
    input  wire logic          sys_clk,
    output logic               issue_valid,
    output fpx_pkg::fpx_kind_e issue_kind,
    output logic [5:0]         exc_flags,
    output logic               ctrl_wr,
    output logic [5:0]         ctrl_wdata
);
    // quiet stream at time zero
    initial
    begin
        issue_valid = 1'b0;
        issue_kind  = fpx_pkg::fpx_kind_none;
        exc_flags   = 6'h00;
        ctrl_wr     = 1'b0;
        ctrl_wdata  = 6'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one instruction per cycle, changed on the falling edge
    task automatic op(input fpx_pkg::fpx_kind_e kind, input logic [5:0] flags, input logic wr,
                      input logic [5:0] wdata);
        @(negedge sys_clk);
        issue_valid = (kind != fpx_pkg::fpx_kind_none);
        issue_kind  = kind;
        // unused lines toggle so a stale value is never mistaken for a real one
        exc_flags   = (kind == fpx_pkg::fpx_kind_arith) ? flags : ~exc_flags;
        ctrl_wr     = wr;
        ctrl_wdata  = wr ? wdata : ~ctrl_wdata;
    endtask : op
endmodule : fpx_issue_model

//--- test_fpx_exception_sync.sv
// self-checking bench for the deferred floating-point trap logic
`timescale 1ns/100ps
module test_fpx_exception_sync;
    logic               sys_clk = 1'b0;
    logic               rst     = 1'b1;
    logic               issue_valid;
    fpx_pkg::fpx_kind_e issue_kind;
    logic [5:0]         exc_flags;
    logic               ctrl_wr;
    logic [5:0]         ctrl_wdata;
    logic               trap_req;
    logic               pending_summary_flag;
    logic [5:0]         status_flags;
    logic [5:0]         exc_masks;
    logic               result_wr;
    logic               fault_halt;
    logic               insn_done;
    logic               store_valid;
    logic [11:0]        store_data;
    int                 fail_count = 0;
    int                 cmp_count  = 0;
    fpx_pkg::fpx_kind_e kinds [4] = '{fpx_pkg::fpx_kind_init, fpx_pkg::fpx_kind_stenv,
                                      fpx_pkg::fpx_kind_save, fpx_pkg::fpx_kind_clex};

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    fpx_issue_model u_src (.sys_clk(sys_clk), .issue_valid(issue_valid), .issue_kind(issue_kind),
                           .exc_flags(exc_flags), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata));

    fpx_exception_sync u_dut (.sys_clk(sys_clk), .rst(rst), .issue_valid(issue_valid),
        .issue_kind(issue_kind), .exc_flags(exc_flags), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .trap_req(trap_req), .pending_summary_flag(pending_summary_flag), .status_flags(status_flags),
        .exc_masks(exc_masks), .result_wr(result_wr), .fault_halt(fault_halt), .insn_done(insn_done),
        .store_valid(store_valid), .store_data(store_data));

    ////////////////////////////////////////////////////////////////////////////////
    // comparisons and closing report
    task automatic chk_vec(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_vec

    task automatic chk_bit(input logic got, input logic exp);
        chk_vec({11'h000, got}, {11'h000, exp});
    endtask : chk_bit

    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios; each check follows the edge that took the instruction issued by the op call before the last one
    task automatic t_masked();
        u_src.op(fpx_pkg::fpx_kind_arith, 6'h20, 1'b0, 6'h00);
        u_src.op(fpx_pkg::fpx_kind_clex, 6'h00, 1'b0, 6'h00);
        chk_bit(result_wr, 1'b1);
        chk_bit(fault_halt, 1'b0);
        chk_bit(pending_summary_flag, 1'b0);
        chk_vec({status_flags, exc_masks}, 12'h83f);
        u_src.op(fpx_pkg::fpx_kind_none, 6'h00, 1'b0, 6'h00);
        chk_vec({status_flags, exc_masks}, 12'h03f);
        $display("test masked done");
    endtask : t_masked

    task automatic t_pend();
        u_src.op(fpx_pkg::fpx_kind_none, 6'h00, 1'b1, 6'h00);
        u_src.op(fpx_pkg::fpx_kind_arith, 6'h04, 1'b0, 6'h00);
        u_src.op(fpx_pkg::fpx_kind_none, 6'h00, 1'b0, 6'h00);
        chk_bit(fault_halt, 1'b1);
        chk_bit(trap_req, 1'b0);
        chk_bit(result_wr, 1'b0);
        chk_bit(pending_summary_flag, 1'b1);
        u_src.op(fpx_pkg::fpx_kind_wait, 6'h00, 1'b0, 6'h00);
        chk_bit(trap_req, 1'b0);
        chk_bit(pending_summary_flag, 1'b1);
        u_src.op(fpx_pkg::fpx_kind_arith, 6'h01, 1'b0, 6'h00);
        chk_bit(trap_req, 1'b1);
        chk_bit(insn_done, 1'b0);
        chk_bit(result_wr, 1'b0);
        u_src.op(fpx_pkg::fpx_kind_none, 6'h00, 1'b0, 6'h00);
        chk_bit(trap_req, 1'b1);
        chk_vec({status_flags, exc_masks}, 12'h100);
        $display("test pending done");
    endtask : t_pend

    task automatic t_nowait();
        for (int i = 0; i < 2; i++)
        begin
            u_src.op(i ? fpx_pkg::fpx_kind_stcw : fpx_pkg::fpx_kind_stsw, 6'h00, 1'b0, 6'h00);
            u_src.op(fpx_pkg::fpx_kind_wait, 6'h00, 1'b0, 6'h00);
            chk_bit(trap_req, 1'b0);
            chk_bit(insn_done, 1'b1);
            chk_bit(store_valid, 1'b1);
            chk_vec(store_data, 12'h004);
            u_src.op(fpx_pkg::fpx_kind_none, 6'h00, 1'b0, 6'h00);
            chk_bit(trap_req, 1'b1);
        end
        foreach (kinds[i])
        begin
            u_src.op(fpx_pkg::fpx_kind_clex, 6'h00, 1'b1, 6'h00);
            u_src.op(fpx_pkg::fpx_kind_arith, 6'h08, 1'b0, 6'h00);
            u_src.op(kinds[i], 6'h00, 1'b0, 6'h00);
            chk_bit(fault_halt, 1'b1);
            chk_bit(result_wr, 1'b1);
            u_src.op(fpx_pkg::fpx_kind_wait, 6'h00, 1'b0, 6'h00);
            chk_bit(trap_req, 1'b0);
            chk_bit(pending_summary_flag, 1'b0);
            u_src.op(fpx_pkg::fpx_kind_none, 6'h00, 1'b0, 6'h00);
            chk_bit(trap_req, 1'b0);
            chk_bit(insn_done, 1'b1);
        end
        $display("test non-waiting done");
    endtask : t_nowait

    ////////////////////////////////////////////////////////////////////////////////
    // hang guard
    initial
    begin
        #100000;
        fail_count++;
        tally_and_finish();
    end

    // main sequence
    initial
    begin
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        chk_vec({status_flags, exc_masks}, 12'h03f);
        chk_vec(store_data, 12'h000);
        chk_bit(pending_summary_flag, 1'b0);
        $display("test reset done");
        t_masked();
        t_pend();
        t_nowait();
        tally_and_finish();
    end
endmodule : test_fpx_exception_sync
